/* rtl/dbc_pkg.sv */
// dbc_pkg: constants, field layout and state types of the bus cycle configuration block.
// assumes one bus clock domain and a synchronous, active-high hardware reset.
`default_nettype none

package dbc_pkg;

  // ************************************************************
  // register addressing and bit positions
  // ************************************************************
  localparam logic [5:0] DBC_CFG_ADDR = 6'h01;
  localparam int DBC_UPPER_HI = 15;
  localparam int DBC_UPPER_LO = 11;
  localparam int DBC_SYNC_BIT = 10;
  localparam int DBC_USR_HI = 9;
  localparam int DBC_USR_LO = 8;
  localparam int DBC_WAIT_HI = 7;
  localparam int DBC_WAIT_LO = 6;
  localparam int DBC_RSVD_BIT = 5;
  localparam int DBC_BLOCK_BIT = 4;
  localparam int DBC_RXL_HI = 3;
  localparam int DBC_RXL_LO = 2;
  localparam int DBC_TXL_HI = 1;
  localparam int DBC_TXL_LO = 0;

  // ************************************************************
  // fifo geometry and request levels in words
  // ************************************************************
  localparam logic [4:0] DBC_FIFO_WORDS = 5'h10;
  localparam logic [3:0][4:0] DBC_RX_LEVELS = {5'h0c, 5'h08, 5'h04, 5'h02};
  localparam logic [3:0][4:0] DBC_TX_LEVELS = {5'h0e, 5'h0c, 5'h08, 5'h04};

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic [4:0] upper;
    logic ready_sync_select;
    logic [1:0] user_pin_levels;
    logic [1:0] wait_cycle_count;
    logic dma_block_select;
    logic [1:0] rx_request_level;
    logic [1:0] tx_request_level;
  } dbc_cfg_type;

  typedef enum logic [1:0] {
    DBC_IDLE = 2'b00,
    DBC_T1 = 2'b01,
    DBC_T2 = 2'b10
  } dbc_phase_type;

  typedef struct packed {
    dbc_cfg_type cfg;
    dbc_phase_type phase;
    logic [1:0] wait_left;
    logic [4:0] words_left;
    logic dir_tx;
    logic ready_meta;
    logic ready_sync;
    logic [15:0] rdata;
  } dbc_state_type;

  localparam dbc_state_type DBC_STATE_RESET = '0;

  // level decoders, shared by request and burst logic
  function automatic logic [4:0] dbc_rx_level(input logic [1:0] code);
    dbc_rx_level = DBC_RX_LEVELS[code];
  endfunction : dbc_rx_level

  function automatic logic [4:0] dbc_tx_level(input logic [1:0] code);
    dbc_tx_level = DBC_TX_LEVELS[code];
  endfunction : dbc_tx_level

endpackage : dbc_pkg

`default_nettype wire

/* rtl/dbc_bus_cycle_config.sv */
// dbc_bus_cycle_config: bus cycle configuration register and the dma cycle sequencer it steers.
// assumes fifo word counts and grant come in synchronous to core_clk_in; ready need be synchronous only when ready_sync_select is set.
`default_nettype none

module dbc_bus_cycle_config
  import dbc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  input wire logic ctrl_reset_mode_in,
  input wire logic [1:0] user_pin_levels_in,
  input wire logic bus_protocol_select_in,
  input wire logic memory_ready_n_in,
  input wire logic [1:0] data_strobe_ack_n_in,
  input wire logic bus_grant_in,
  input wire logic [4:0] rx_words_in,
  input wire logic [4:0] tx_words_in,
  output logic rx_dma_req_out,
  output logic tx_dma_req_out,
  output logic bus_request_out,
  output logic cycle_t1_out,
  output logic cycle_t2_out,
  output logic word_done_out,
  output logic word_is_tx_out
);

  // ************************************************************
  // state and decoded terms
  // ************************************************************
  dbc_state_type q;
  dbc_state_type d;
  logic raw_ready;
  logic cycle_ready;
  logic cfg_write;
  logic [4:0] rx_level;
  logic [4:0] tx_level;
  logic [4:0] tx_room;

  // ready source depends on the bus protocol: plain ready or either strobe ack
  assign raw_ready = bus_protocol_select_in ? ~(&data_strobe_ack_n_in) : ~memory_ready_n_in;
  // async mode trades two extra cycles of latency for metastability safety
  assign cycle_ready = q.cfg.ready_sync_select ? raw_ready : q.ready_sync;

  assign rx_level = dbc_rx_level(q.cfg.rx_request_level);
  assign tx_level = dbc_tx_level(q.cfg.tx_request_level);
  assign tx_room = DBC_FIFO_WORDS - tx_words_in;

  // writes are honoured only in reset mode, so a stray write cannot retime a live burst
  assign cfg_write = reg_wr_in && (reg_addr_in == DBC_CFG_ADDR) && ctrl_reset_mode_in;

  // ************************************************************
  // request and handshake outputs
  // ************************************************************
  assign rx_dma_req_out = (rx_words_in >= rx_level);
  assign tx_dma_req_out = (tx_words_in < tx_level);
  assign bus_request_out = (q.phase != DBC_IDLE) || rx_dma_req_out || tx_dma_req_out;
  assign cycle_t1_out = (q.phase == DBC_T1);
  assign cycle_t2_out = (q.phase == DBC_T2);
  assign word_done_out = clk_en_in && (q.phase == DBC_T2) && (q.wait_left == 2'b00)
    && cycle_ready;
  assign word_is_tx_out = q.dir_tx;
  assign reg_rdata_out = q.rdata;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    d = q;
    // two-flop synchroniser for the asynchronous ready mode; flushed outside T2 so a
    // ready left over from the previous word can never end the next one
    d.ready_meta = raw_ready && (q.phase == DBC_T2);
    d.ready_sync = q.ready_meta && (q.phase == DBC_T2);
    // register write; user pin bits and reserved bit are not writable
    if (cfg_write)
    begin
      d.cfg.upper = reg_wdata_in[DBC_UPPER_HI:DBC_UPPER_LO];
      d.cfg.ready_sync_select = reg_wdata_in[DBC_SYNC_BIT];
      d.cfg.wait_cycle_count = reg_wdata_in[DBC_WAIT_HI:DBC_WAIT_LO];
      d.cfg.dma_block_select = reg_wdata_in[DBC_BLOCK_BIT];
      d.cfg.rx_request_level = reg_wdata_in[DBC_RXL_HI:DBC_RXL_LO];
      d.cfg.tx_request_level = reg_wdata_in[DBC_TXL_HI:DBC_TXL_LO];
    end
    // registered read; unmapped addresses read as zero
    if (reg_rd_in)
    begin
      d.rdata = '0;
      if (reg_addr_in == DBC_CFG_ADDR)
      begin
        d.rdata[DBC_UPPER_HI:DBC_UPPER_LO] = q.cfg.upper;
        d.rdata[DBC_SYNC_BIT] = q.cfg.ready_sync_select;
        d.rdata[DBC_USR_HI:DBC_USR_LO] = q.cfg.user_pin_levels;
        d.rdata[DBC_WAIT_HI:DBC_WAIT_LO] = q.cfg.wait_cycle_count;
        d.rdata[DBC_RSVD_BIT] = 1'b0;
        d.rdata[DBC_BLOCK_BIT] = q.cfg.dma_block_select;
        d.rdata[DBC_RXL_HI:DBC_RXL_LO] = q.cfg.rx_request_level;
        d.rdata[DBC_TXL_HI:DBC_TXL_LO] = q.cfg.tx_request_level;
      end
    end
    // dma cycle sequencer
    unique case (q.phase)
      DBC_IDLE:
      begin
        if (bus_grant_in && rx_dma_req_out)
        begin
          d.dir_tx = 1'b0;
          d.phase = DBC_T1;
          // block mode moves exactly the receive level, else drains the fifo
          d.words_left = q.cfg.dma_block_select ? rx_level : rx_words_in;
        end
        else if (bus_grant_in && tx_dma_req_out)
        begin
          d.dir_tx = 1'b1;
          d.phase = DBC_T1;
          d.words_left = tx_room;
          // block mode never reads more than the room left in the fifo
          if (q.cfg.dma_block_select && (tx_level < tx_room))
          begin
            d.words_left = tx_level;
          end
        end
      end
      DBC_T1:
      begin
        d.phase = DBC_T2;
        d.wait_left = q.cfg.wait_cycle_count;
      end
      DBC_T2:
      begin
        if (q.wait_left != 2'b00)
        begin
          d.wait_left = q.wait_left - 2'b01;
        end
        else if (cycle_ready)
        begin
          d.words_left = q.words_left - 5'h01;
          d.phase = (q.words_left == 5'h01) ? DBC_IDLE : DBC_T1;
        end
      end
      default:
      begin
        d.phase = DBC_IDLE;
      end
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  // user pins are sampled every reset cycle, so the last one before release sticks
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      q <= DBC_STATE_RESET;
      q.cfg.user_pin_levels <= user_pin_levels_in;
    end
    else if (clk_en_in)
    begin
      q <= d;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  rx_level_two_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (q.cfg.rx_request_level == 2'b00) |-> (rx_dma_req_out == (rx_words_in > 5'h01)))
    else $error("receive level 00 is not two words");

  rx_level_twelve_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (q.cfg.rx_request_level == 2'b11) |-> (rx_dma_req_out == (rx_words_in > 5'h0b)))
    else $error("receive level 11 is not twelve words");

  rx_request_gate_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (rx_words_in < 5'h02) |-> !rx_dma_req_out)
    else $error("receive request below every level");

  tx_level_top_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (q.cfg.tx_request_level == 2'b11) |-> (tx_dma_req_out == (tx_words_in < 5'h0e)))
    else $error("transmit level 11 is not fourteen words");

  user_pins_catch_a: assert property (@(posedge core_clk_in)
    $fell(sys_rst_in) |-> (q.cfg.user_pin_levels == $past(user_pin_levels_in)))
    else $error("user pins not caught at reset release");

  user_pins_hold_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in) |-> $stable(q.cfg.user_pin_levels))
    else $error("user pin bits changed outside reset");

  wait_load_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (cycle_t1_out && clk_en_in) |=> (cycle_t2_out && (q.wait_left == $past(q.cfg.wait_cycle_count))))
    else $error("wait states not loaded on entry to T2");

  wait_blocks_done_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (cycle_t2_out && (q.wait_left != 2'b00)) |-> !word_done_out)
    else $error("dma word ended during an added wait state");

  async_ready_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (cycle_t2_out && !q.cfg.ready_sync_select && !q.ready_sync) |-> !word_done_out)
    else $error("async ready used before synchronisation");

  async_fresh_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (word_done_out && !q.cfg.ready_sync_select)
      |-> ($past(cycle_t2_out) && $past(cycle_t2_out, 2)))
    else $error("async ready taken from an earlier cycle");

  sync_ready_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (cycle_t2_out && clk_en_in && q.cfg.ready_sync_select && (q.wait_left == 2'b00)
      && raw_ready) |-> word_done_out)
    else $error("sync ready not taken directly");

  block_rx_size_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    ((q.phase == DBC_IDLE) && clk_en_in && bus_grant_in && rx_dma_req_out
      && q.cfg.dma_block_select) |=> (q.words_left == $past(rx_level)))
    else $error("block receive burst size wrong");

  fill_rx_size_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    ((q.phase == DBC_IDLE) && clk_en_in && bus_grant_in && rx_dma_req_out
      && !q.cfg.dma_block_select) |=> (q.words_left == $past(rx_words_in)))
    else $error("empty/fill receive burst not draining fifo");

  burst_end_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (word_done_out && (q.words_left == 5'h01)) |=> (q.phase == DBC_IDLE))
    else $error("burst ran past its last word");

  reserved_zero_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    reg_rdata_out[DBC_RSVD_BIT] == 1'b0)
    else $error("reserved bit reads nonzero");

endmodule : dbc_bus_cycle_config

`default_nettype wire

/* tb/dbc_mem_model.sv */
// dbc_mem_model: memory side answering dma cycles by ready or strobe acks.
// assumes the t2 marker of the sequencer, all on the bus clock.
`default_nettype none

module dbc_mem_model (
  input wire logic clk_in,
  input wire logic t2_in,
  input wire logic proto_in,
  input wire logic [1:0] delay_in,
  output logic ready_n_out,
  output logic [1:0] ack_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q;
  logic ans;

  // ****************
  // slow or prompt answer
  // ****************
  // count t2 cycles, saturating so a long wait never wraps
  always_ff @(posedge clk_in)
  begin
    wait_q <= t2_in ? (wait_q == 2'h3 ? wait_q : wait_q + 2'h1) : 2'h0;
  end
  // answer held from after the delay through the sampling edge
  assign ans = t2_in && (wait_q >= delay_in);
  // lines idle high when not answering, as pulled up
  assign ready_n_out = !(ans && !proto_in);
  assign ack_n_out = {2{!(ans && proto_in)}};
endmodule : dbc_mem_model

`default_nettype wire

/* tb/tb_top.sv */
// tb_top: register and dma burst tests of the bus cycle configuration block.
// assumes the memory model answers on the far side of the sequencer.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rmode = 1'b1, proto = 1'b0;
  logic grant = 1'b0, rxreq, txreq, breq, t1, t2, wdone, wtx, rdy_n;
  logic [1:0] upins = 2'h0, dly = 2'h0, ack_n;
  logic [5:0] addr = 6'h00;
  logic [4:0] rxw = 5'h00, txw = 5'h10;
  logic [15:0] wdata = 16'h0000, rdata, v;
  int mismatches = 0, total_checks = 0;
  int rxl[4] = '{2, 4, 8, 12};
  int txl[4] = '{4, 8, 12, 14};

  always #25 clk = ~clk;

  dbc_bus_cycle_config i_dbc_bus_cycle_config (
    .core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .ctrl_reset_mode_in(rmode), .user_pin_levels_in(upins),
    .bus_protocol_select_in(proto), .memory_ready_n_in(rdy_n),
    .data_strobe_ack_n_in(ack_n), .bus_grant_in(grant), .rx_words_in(rxw),
    .tx_words_in(txw), .rx_dma_req_out(rxreq), .tx_dma_req_out(txreq),
    .bus_request_out(breq), .cycle_t1_out(t1), .cycle_t2_out(t2),
    .word_done_out(wdone), .word_is_tx_out(wtx));

  dbc_mem_model i_dbc_mem_model (.clk_in(clk), .t2_in(t2), .proto_in(proto),
    .delay_in(dly), .ready_n_out(rdy_n), .ack_n_out(ack_n));

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // pins change right after release, so only the held level may show
  task automatic hrst(input logic [1:0] p);
    upins <= p;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    upins <= ~p;
  endtask : hrst

  task automatic wr16(input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= 6'h01;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr16

  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd16

  // grant is dropped once t1 shows, so exactly one burst runs
  task automatic burst(input logic [15:0] cfg, input logic [4:0] nr, input logic [4:0] nt,
    input logic [1:0] d, input int nw, input int nt2);
    int words;
    int t2s;
    bit seen1;
    words = 0;
    t2s = 0;
    seen1 = 0;
    wr16(cfg);
    @(posedge clk);
    rxw <= nr;
    txw <= nt;
    dly <= d;
    grant <= 1'b1;
    repeat (80)
    begin
      @(negedge clk);
      seen1 = seen1 || (t1 === 1'b1);
      t2s += (words == 0 && t2 === 1'b1) ? 1 : 0;
      words += (wdone === 1'b1) ? 1 : 0;
      @(posedge clk);
      grant <= grant && !seen1;
    end
    chk(16'(words), 16'(nw));
    if (nt2 >= 0) chk(16'(t2s), 16'(nt2));
    chk(16'(wtx), 16'(nt < 5'h10));
    rxw <= 5'h00;
    txw <= 5'h10;
  endtask : burst

  // ****************
  // test sequence
  // ****************
  initial
  begin
    hrst(2'b10);
    rd16(6'h01, v);
    chk(v, 16'h0200);
    chk(16'(breq), 16'h0000);
    wr16(16'hffff);
    rd16(6'h01, v);
    chk(v, 16'hfedf);
    rd16(6'h02, v);
    chk(v, 16'h0000);
    rmode <= 1'b0;
    wr16(16'h0000);
    rd16(6'h01, v);
    chk(v, 16'hfedf);
    rmode <= 1'b1;
    hrst(2'b01);
    rd16(6'h01, v);
    chk(v, 16'h0100);
    for (int c = 0; c < 4; c++)
    begin
      wr16(16'(c * 5));
      @(posedge clk);
      rxw <= 5'(rxl[c] - 1);
      txw <= 5'(txl[c] - 1);
      #1;
      chk(16'(rxreq), 16'h0000);
      chk(16'(txreq), 16'h0001);
      chk(16'(breq), 16'h0001);
      @(posedge clk);
      rxw <= 5'(rxl[c]);
      txw <= 5'(txl[c]);
      #1;
      chk(16'(rxreq), 16'h0001);
      chk(16'(txreq), 16'h0000);
    end
    for (int w = 0; w < 4; w++)
    begin
      @(posedge clk);
      proto <= w[0];
      burst(16'h0400 | 16'(w << 6), 5'(w + 2), 5'h10, 2'h0, w + 2, w + 1);
    end
    burst(16'h0400, 5'h02, 5'h10, 2'h2, 2, 3);
    burst(16'h0414, 5'h10, 5'h10, 2'h0, 4, 1);
    burst(16'h041c, 5'h10, 5'h10, 2'h0, 12, 1);
    burst(16'h0410, 5'h00, 5'h03, 2'h0, 4, 1);
    burst(16'h0403, 5'h00, 5'h0d, 2'h0, 3, 1);
    burst(16'h0000, 5'h03, 5'h10, 2'h0, 3, 3);
    end_of_test();
  end

  // hang guard, well beyond the length of the sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
